// ==== hdl/toggle_relay.sv ====
// Purpose: Toggle relay with preset and clear inputs and selectable priority.
// Assumes: One scan per enabled mclk cycle; all inputs synchronous except reset, which is asynchronous.
// Notes: powerRestore marks the first scan after a power loss.
`include "toggle_relay_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module toggle_relay (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic powerRestore,
	input wire logic presetIn,
	input wire logic clearIn,
	input wire logic trigIn,
	input wire logic presetDominant,
	input wire logic retainEn,
	output logic relayOut,
	output logic overrideActive,
	output logic toggleTaken
);

	toggle_relay_pkg::relay_in_s in;
	toggle_relay_pkg::relay_cfg_s cfg;
	toggle_relay_pkg::relay_state_e state_q;
	toggle_relay_pkg::relay_state_e state_d;
	logic trigRise;
	logic restoreClears;
	logic nextOut;
	logic overrideOut;

	// Gather the live inputs and the configuration
	assign in = '{preset: presetIn, clear: clearIn, trig: trigIn};
	assign cfg = '{presetDominant: presetDominant, retain: retainEn};
	assign restoreClears = powerRestore & ~cfg.retain;

	// Edge history is realigned on any restore, avoiding a spurious toggle
	trig_edge_detect u_edge (
		.mclk(mclk),
		.reset(reset),
		.clkEn(clkEn),
		.realign(powerRestore),
		.trig(in.trig),
		.rise(trigRise)
	);

	// Level forced by the override inputs, dominance deciding a tie
	always_comb begin
		overrideOut = `TR_OUT_RESET;
		if (in.preset && in.clear) begin
			overrideOut = (cfg.presetDominant == `TR_PRESET_DOMINANT);
		end else if (in.preset) begin
			overrideOut = 1'b1;
		end else begin
			overrideOut = 1'b0;
		end
	end

	// Next state; restore has priority over every input in its scan
	always_comb begin
		state_d = state_q;
		if (restoreClears) begin
			state_d = toggle_relay_pkg::RELAY_OFF;
		end else if (powerRestore) begin
			state_d = state_q;
		end else if (in.preset || in.clear) begin
			state_d = overrideOut ? toggle_relay_pkg::RELAY_ON
				: toggle_relay_pkg::RELAY_OFF;
		end else begin
			case (state_q)
				toggle_relay_pkg::RELAY_OFF: begin
					if (trigRise) begin
						state_d = toggle_relay_pkg::RELAY_ON;
					end
				end
				toggle_relay_pkg::RELAY_ON: begin
					if (trigRise) begin
						state_d = toggle_relay_pkg::RELAY_OFF;
					end
				end
				// Illegal code recovers to off
				default: begin
					state_d = toggle_relay_pkg::RELAY_OFF;
				end
			endcase
		end
	end

	assign nextOut = (state_d == toggle_relay_pkg::RELAY_ON);

	// State register; holds when nothing acts
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= toggle_relay_pkg::RELAY_OFF;
		end else if (clkEn) begin
			state_q <= state_d;
		end
	end

	// Output copy kept in its own flop so the pin is registered
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			relayOut <= `TR_OUT_RESET;
		end else if (clkEn) begin
			relayOut <= nextOut;
		end
	end

	// Status flags: override in force, and a toggle taken this scan
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			overrideActive <= `TR_FLAG_RESET;
			toggleTaken <= `TR_FLAG_RESET;
		end else if (clkEn) begin
			overrideActive <= ~powerRestore & (in.preset | in.clear);
			toggleTaken <= ~powerRestore & ~in.preset & ~in.clear & trigRise;
		end
	end

	// Assertions

	chk_edge_toggles: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !powerRestore && !presetIn && !clearIn && trigRise)
		|=> (relayOut == !$past(relayOut)) && toggleTaken
	) else $error("Trigger edge did not toggle the output");

	chk_trig_ignored: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !powerRestore && (presetIn || clearIn) && trigIn)
		|=> !toggleTaken && overrideActive
	) else $error("Trigger acted during an override");

	chk_preset_high: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !powerRestore && presetIn && !clearIn) |=> relayOut
	) else $error("Preset did not drive the output high");

	chk_clear_low: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !powerRestore && clearIn && !presetIn) |=> !relayOut
	) else $error("Clear did not drive the output low");

	chk_clear_wins: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !powerRestore && presetIn && clearIn && !presetDominant)
		|=> !relayOut
	) else $error("Clear-dominant tie did not give low");

	chk_preset_wins: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !powerRestore && presetIn && clearIn && presetDominant)
		|=> relayOut
	) else $error("Preset-dominant tie did not give high");

	chk_restore_clears: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && powerRestore && !retainEn) |=> !relayOut
	) else $error("Non-retentive restore left the output set");

	chk_restore_keeps: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && powerRestore && retainEn) |=> $stable(relayOut)
	) else $error("Retentive restore changed the output");

	chk_tie_follows_cfg: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !powerRestore && presetIn && clearIn)
		|=> relayOut == $past(presetDominant)
	) else $error("Tie result does not follow the dominance choice");

	chk_idle_holds: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !powerRestore && !presetIn && !clearIn && !trigRise)
		|=> $stable(relayOut)
	) else $error("Output changed with nothing acting");

	chk_freeze_holds: assert property (
		@(posedge mclk) disable iff (reset)
		!clkEn |=> $stable(relayOut) && $stable(state_q)
	) else $error("State moved while the clock enable was low");

	chk_toggle_only_edge: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !(trigRise && !powerRestore && !presetIn && !clearIn))
		|=> !toggleTaken
	) else $error("Toggle flag set without a taken edge");

	chk_override_flag: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && !powerRestore && !presetIn && !clearIn)
		|=> !overrideActive
	) else $error("Override flag set with no override");

	chk_restore_quiet: assert property (
		@(posedge mclk) disable iff (reset)
		(clkEn && powerRestore) |=> !overrideActive && !toggleTaken
	) else $error("Flags set in a restore scan");

	chk_out_mirrors: assert property (
		@(posedge mclk) disable iff (reset)
		1'b1 |-> relayOut == (state_q == toggle_relay_pkg::RELAY_ON)
	) else $error("Output flop disagrees with relay state");

endmodule : toggle_relay

`default_nettype wire

// ==== hdl/toggle_relay_cfg.svh ====
// Purpose: Constants of the toggle relay: reset values and state codes.
// Assumes: Included by bare name wherever the values are needed.
// Notes: Definitions only; guarded against double inclusion.
`ifndef TOGGLE_RELAY_CFG_SVH
`define TOGGLE_RELAY_CFG_SVH

// Output level after power-up or a non-retentive restore
`define TR_OUT_RESET 1'b0
// Trigger history after power-up
`define TR_TRIG_RESET 1'b0
// Status flags after power-up
`define TR_FLAG_RESET 1'b0
// One-hot state codes
`define TR_ST_OFF 2'h1
`define TR_ST_ON 2'h2
// Dominance selector values
`define TR_CLEAR_DOMINANT 1'b0
`define TR_PRESET_DOMINANT 1'b1

`endif

// ==== hdl/toggle_relay_pkg.sv ====
// Purpose: Types shared by the toggle relay files.
// Assumes: toggle_relay_cfg.svh supplies the numeric codes.
// Notes: Nothing here is imported; users write the package name.
`include "toggle_relay_cfg.svh"

package toggle_relay_pkg;

	// One-hot relay state
	typedef enum logic [1:0] {
		RELAY_OFF = `TR_ST_OFF,
		RELAY_ON = `TR_ST_ON
	} relay_state_e;

	// Live inputs sampled each scan
	typedef struct packed {
		logic preset;
		logic clear;
		logic trig;
	} relay_in_s;

	// Configuration chosen for the block
	typedef struct packed {
		logic presetDominant;
		logic retain;
	} relay_cfg_s;

endpackage : toggle_relay_pkg

// ==== hdl/trig_edge_detect.sv ====
// Purpose: Rising-edge detector for the trigger input.
// Assumes: Trigger is synchronous to mclk.
// Notes: Realign masks rise for its scan, so no edge is seen on resume.
`include "toggle_relay_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module trig_edge_detect (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic realign,
	input wire logic trig,
	output logic rise
);

	logic trigPrev_q;

	// Compare against the level of the previous scan
	assign rise = trig & ~trigPrev_q & ~realign;

	// History register, frozen while the clock enable is low
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			trigPrev_q <= `TR_TRIG_RESET;
		end else if (clkEn) begin
			trigPrev_q <= trig;
		end
	end

endmodule : trig_edge_detect

`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the toggle relay.
// Assumes: Inputs change at the falling edge of mclk.
// Notes: A scan-by-scan model is compared after every scan.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic mclk = 1'h0;
	logic reset = 1'h1;
	logic clkEn = 1'h0;
	logic powerRestore = 1'h0;
	logic presetIn = 1'h0;
	logic clearIn = 1'h0;
	logic trigIn = 1'h0;
	logic presetDominant = 1'h0;
	logic retainEn = 1'h0;
	logic relayOut, overrideActive, toggleTaken;
	logic mOut, mOv, mTt, mPrev;
	integer seed = 32'hf6d0c6a7;
	int n_errors = 0;
	int check_count = 0;
	int i;

	toggle_relay dut_u (.mclk(mclk), .reset(reset), .clkEn(clkEn),
		.powerRestore(powerRestore), .presetIn(presetIn), .clearIn(clearIn),
		.trigIn(trigIn), .presetDominant(presetDominant), .retainEn(retainEn),
		.relayOut(relayOut), .overrideActive(overrideActive),
		.toggleTaken(toggleTaken));

	// 250 MHz scan clock
	always #2 mclk = ~mclk;

	task automatic check(input logic seen, input logic exp);
		check_count++;
		if (seen !== exp) begin
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			n_errors++;
		end
	endtask : check

	task automatic give_verdict();
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	// Cold start: model cleared along with the design
	task automatic do_reset();
		reset = 1'h1;
		clkEn = 1'h0;
		{mOut, mOv, mTt, mPrev} = 4'h0;
		repeat (3) @(negedge mclk);
		reset = 1'h0;
	endtask : do_reset

	// One scan: drive, let the edge land, update model, compare
	task automatic step(input logic en, rs, pre, clr, tr, pd, rt);
		{clkEn, powerRestore, presetIn, clearIn} = {en, rs, pre, clr};
		{trigIn, presetDominant, retainEn} = {tr, pd, rt};
		@(posedge mclk);
		if (en) begin
			if (rs) begin
				if (!rt) mOut = 1'h0;
				{mOv, mTt} = 2'h0;
			end else if (pre | clr) begin
				mOut = (pre & clr) ? pd : pre;
				{mOv, mTt} = 2'h2;
			end else if (tr & !mPrev) begin
				mOut = ~mOut;
				{mOv, mTt} = 2'h1;
			end else begin
				{mOv, mTt} = 2'h0;
			end
			mPrev = tr;
		end
		@(negedge mclk);
		check(relayOut, mOut); // output level
		check(overrideActive, mOv); // override flag
		check(toggleTaken, mTt); // toggle flag
	endtask : step

	// Hang guard; a run past the bound counts as a mismatch
	initial begin
		repeat (100000) @(posedge mclk);
		n_errors++;
		give_verdict();
	end

	initial begin
		do_reset();
		check(relayOut, 1'h0); // cold start low
		// Toggle walk, then holding while trigger stays high
		step(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
		step(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
		check(relayOut, 1'h1); // first edge sets
		step(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
		check(relayOut, 1'h1); // level holds
		step(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
		step(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
		check(relayOut, 1'h0); // next edge clears
		// Output first forced to the losing level, so a tie must move it
		for (i = 0; i < 2; i++) begin
			step(1'h1, 1'h0, ~i[0], i[0], 1'h0, i[0], 1'h0);
			step(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, i[0], 1'h0);
			check(relayOut, i[0]); // dominance decides
			check(toggleTaken, 1'h0); // edge ignored
		end
		// Restore with and without retention
		step(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
		step(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
		step(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
		check(relayOut, 1'h1); // retained
		step(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
		check(relayOut, 1'h0); // not retained
		// Random scans; a second reset in mid-run
		for (i = 0; i < 3000; i++) begin
			if (i == 1500) begin
				do_reset();
				check(relayOut, 1'h0); // warm restart low
			end
			step(($random(seed) & 7) != 0, ($random(seed) & 15) == 0,
				($random(seed) & 3) == 0, ($random(seed) & 3) == 0,
				1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
		end
		give_verdict();
	end
endmodule : tb_top

`default_nettype wire
